// File: logic/sensor_channel_regs_defines.vh
// register offsets, field positions, reset values and timing counts for the channel register bank
`ifndef SENSOR_CHANNEL_REGS_DEFINES_VH
`define SENSOR_CHANNEL_REGS_DEFINES_VH

`define ADDR_CHANNEL_CONTROL  6'h02
`define ADDR_NO_OPERATION     6'h03
`define ADDR_STATUS_FIRST     6'h04
`define ADDR_STATUS_SECOND    6'h05
`define ADDR_STATUS_THIRD     6'h06

`define RST_CHANNEL_CONTROL   16'h0442
`define RST_NO_OPERATION      16'h0002
`define MASK_CHANNEL_CONTROL  16'h077b

// channel_control fields
`define CC_REG_EN             10
`define CC_TRIG2_HI           9
`define CC_TRIG2_LO           8
`define CC_PERMIT2            6
`define CC_LINE_EN2           5
`define CC_TRIG1_HI           4
`define CC_TRIG1_LO           3
`define CC_PERMIT1            1
`define CC_LINE_EN1           0

// trigger codes
`define TRIG_SHORT            2'h1
`define TRIG_LONG             2'h2

// pin timeout: 100 us at 100 MHz
`define PIN_TIMEOUT_US        100
`define CLK_MHZ               100
`define PIN_TIMEOUT_CYCLES    (`PIN_TIMEOUT_US * `CLK_MHZ)

`endif

// File: logic/sensor_channel_ctrl_status_regs.v
// control and status register bank of a two-channel sensor-line transceiver
// interface notes
// register strobes are one cycle wide and may come back to back
// read data appears on the edge after the read strobe and holds until the next read
// status reads clear on the read edge, so the returned word is the pre-clear value
// an event in the clearing cycle is kept: a repeated report beats a lost fault
// trigger codes come from the write data, not the stored field, so each fires once
// a trigger needs its line enabled both before and in the write that carries it
// the pin timeout count assumes the 100 MHz clock; another clock needs a new count
// trigger pins pass three flops; a level counts once stages two and three agree
// monitor inputs share this clock and are used without synchronisers
// regulator lockout, short to ground and overheat wait for a host confirmation write
// reserved control bits are masked on write so they always read back as zero
// the no-operation index stores nothing; reading it returns the global word
// an unmapped read returns zero; port errors arrive as an input from the frame logic
// queue lock: a full-read in the same cycle as empty keeps the lock
// live status bits are never stored, so they show the monitor as it is now
// second status undervolt bits follow the line unless the coupling test runs
// summary bit masks only battery and undervolt, and only during the test
// pulse requests last one cycle; the pulse generator must catch them every cycle
`timescale 1ns/1ps
`include "sensor_channel_regs_defines.vh"

module sensor_channel_ctrl_status_regs (
    // clock and reset
    input  wire        clock_in,
    input  wire        sys_rst_in,
    // register port from the serial frame decoder
    input  wire [5:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [15:0] reg_wdata_in,
    output reg  [15:0] reg_rdata_out,
    // reset causes
    input  wire        clock_fault_reset_in,
    // global status summary for frame replies
    output wire [15:0] global_status_out,
    output wire        summary_status_bit_out,
    // control outputs
    output wire        regulator_enable_out,
    output wire [1:0]  line_enable_out,
    output wire [1:0]  pulse_permit_out,
    output reg  [1:0]  short_pulse_req_out,
    output reg  [1:0]  long_pulse_req_out,
    // channel mode from configuration
    input  wire [1:0]  sync_mode_in,
    input  wire [1:0]  buffer_in_use_in,
    // live monitor inputs (same clock)
    input  wire        coupling_test_done_in,
    input  wire        coupling_test_aborted_in,
    input  wire        coupling_test_running_in,
    input  wire        port_fault_in,
    input  wire        trim_crc_error_in,
    input  wire        regulator_undervolt_in,
    input  wire        regulator_overvolt_in,
    input  wire        regulator_lockout_in,
    input  wire [1:0]  buffer_write_in,
    input  wire [1:0]  buffer_pending_in,
    input  wire [1:0]  pulse_slow_in,
    input  wire [1:0]  pulse_low_in,
    input  wire [1:0]  pulse_active_in,
    input  wire [15:0] line_fault_in,
    input  wire        selftest_write_enable_in,
    input  wire        init_data_ready_in,
    input  wire        regulator_on_in,
    input  wire [1:0]  line_on_in,
    input  wire        queue_full_read_in,
    input  wire        queue_empty_in,
    input  wire [1:0]  pin_stuck_high_in,
    // trigger pins, asynchronous
    input  wire [1:0]  trigger_pin_in
);

    // register state
    reg  [15:0] ctrl_q;
    reg  [15:0] ctrl_d;
    reg  [15:0] status1_q;
    reg  [15:0] status1_d;
    reg  [15:0] status2_q;
    reg  [15:0] status2_d;
    // third status sticky flags
    reg         queue_lock_q;
    reg  [1:0]  pin_level_q;
    reg         clock_fault_q;
    reg         reset_seen_q;
    // trigger pin synchroniser and timeout
    reg  [1:0]  pin_s1_q;
    reg  [1:0]  pin_s2_q;
    reg  [1:0]  pin_s3_q;
    reg  [1:0]  pin_q;
    reg  [13:0] pin_cnt_q [0:1];
    reg  [1:0]  pin_tout_q;

    wire        wr_ctrl;
    wire        rd_s1;
    wire        rd_s2;
    wire        rd_s3;
    wire [15:0] live1;
    wire [15:0] status1_view;
    wire [15:0] status2_view;
    wire [15:0] status3_view;
    wire [15:0] sum_mask;
    wire [1:0]  new_trig [0:1];
    wire [1:0]  trig_ok;
    // separate loop indices, one per process, so each has a single writer
    integer     i;
    integer     j;
    integer     k;

    // address decode; a strobe on any other index changes nothing here
    // writes to the no-operation index fall through with no effect
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_CHANNEL_CONTROL);
    assign rd_s1   = reg_rd_in && (reg_addr_in == `ADDR_STATUS_FIRST);
    assign rd_s2   = reg_rd_in && (reg_addr_in == `ADDR_STATUS_SECOND);
    assign rd_s3   = reg_rd_in && (reg_addr_in == `ADDR_STATUS_THIRD);

    // control outputs straight from the register
    // enables act from the stored bits with no extra delay
    assign regulator_enable_out = ctrl_q[`CC_REG_EN];
    assign line_enable_out      = {ctrl_q[`CC_LINE_EN2], ctrl_q[`CC_LINE_EN1]};
    // permit is only meaningful in synchronous mode; otherwise passes freely
    assign pulse_permit_out     = {ctrl_q[`CC_PERMIT2], ctrl_q[`CC_PERMIT1]} | ~sync_mode_in;

    // control register write, reserved bits forced to zero
    // a write replaces the whole word; there is no partial update
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata_in & `MASK_CHANNEL_CONTROL;
        end
    end

    // control register; reads leave it alone
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_q <= `RST_CHANNEL_CONTROL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // trigger decode is taken from the write data, so a held code never retriggers
    // index 0 is channel one, matching the output bit order
    assign new_trig[0] = reg_wdata_in[`CC_TRIG1_HI:`CC_TRIG1_LO];
    assign new_trig[1] = reg_wdata_in[`CC_TRIG2_HI:`CC_TRIG2_LO];
    assign trig_ok     = {reg_wdata_in[`CC_LINE_EN2] & ctrl_q[`CC_LINE_EN2],
                          reg_wdata_in[`CC_LINE_EN1] & ctrl_q[`CC_LINE_EN1]};

    // one-cycle pulse requests, only on the loading write
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            short_pulse_req_out <= 2'h0;
            long_pulse_req_out  <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                short_pulse_req_out[i] <= 1'b0;
                long_pulse_req_out[i]  <= 1'b0;
                // a half-enabled line never fires: a lost trigger is safer
                // than a pulse on a line that is just switching on or off
                if (wr_ctrl && trig_ok[i]) begin
                    if (buffer_in_use_in[i]) begin
                        // buffer decides the length; any valid code starts it
                        short_pulse_req_out[i] <= (new_trig[i] == `TRIG_SHORT) ||
                                                  (new_trig[i] == `TRIG_LONG);
                    end else begin
                        short_pulse_req_out[i] <= (new_trig[i] == `TRIG_SHORT);
                        long_pulse_req_out[i]  <= (new_trig[i] == `TRIG_LONG);
                    end
                end
            end
        end
    end

    // trigger pin synchroniser, change accepted once stages two and three agree
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            pin_s3_q <= 2'h0;
            pin_q    <= 2'h0;
        end else begin
            pin_s1_q <= trigger_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            // stage one may be metastable, so only stages two and three feed the test
            for (j = 0; j < 2; j = j + 1) begin
                if (pin_s2_q[j] == pin_s3_q[j]) begin
                    pin_q[j] <= pin_s3_q[j];
                end
            end
        end
    end

    // pin active time during a pulse; saturating counter gives a single event
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            pin_cnt_q[0] <= 14'h0000;
            pin_cnt_q[1] <= 14'h0000;
            pin_tout_q   <= 2'h0;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                pin_tout_q[k] <= 1'b0;
                // a pin released before the limit restarts the count
                if (!(pin_q[k] && pulse_active_in[k])) begin
                    pin_cnt_q[k] <= 14'h0000;
                end else if (pin_cnt_q[k] < `PIN_TIMEOUT_CYCLES) begin
                    pin_cnt_q[k] <= pin_cnt_q[k] + 14'h0001;
                end else if (pin_cnt_q[k] == `PIN_TIMEOUT_CYCLES) begin
                    // stops one past the limit, so one event per stuck pin
                    pin_cnt_q[k] <= pin_cnt_q[k] + 14'h0001;
                    pin_tout_q[k] <= 1'b1;
                end
            end
        end
    end

    // live bits of the first status register
    assign live1 = {2'b00, coupling_test_running_in, 1'b0, trim_crc_error_in, 1'b0,
                    regulator_overvolt_in, 9'h000};

    // first status: latched events, set wins over read clear
    always @* begin
        status1_d = status1_q;
        if (rd_s1) begin
            status1_d = status1_q & 16'h0100;
        end
        if (wr_ctrl && !reg_wdata_in[`CC_REG_EN]) begin
            status1_d[8] = 1'b0;
        end
        // events are ORed in last, so a set in the read cycle survives
        // coupling test outcome and port errors
        status1_d[15] = status1_d[15] | coupling_test_done_in;
        status1_d[14] = status1_d[14] | coupling_test_aborted_in;
        status1_d[12] = status1_d[12] | port_fault_in;
        // regulator supply faults
        status1_d[10] = status1_d[10] | regulator_undervolt_in;
        status1_d[8]  = status1_d[8]  | regulator_lockout_in;
        // pin timeouts per channel
        status1_d[7]  = status1_d[7]  | pin_tout_q[1];
        status1_d[3]  = status1_d[3]  | pin_tout_q[0];
        // buffer writes while data is still pending
        status1_d[6]  = status1_d[6]  | (buffer_write_in[1] & buffer_pending_in[1]);
        status1_d[2]  = status1_d[2]  | (buffer_write_in[0] & buffer_pending_in[0]);
        // pulse quality monitors
        status1_d[5]  = status1_d[5]  | pulse_slow_in[1];
        status1_d[1]  = status1_d[1]  | pulse_slow_in[0];
        status1_d[4]  = status1_d[4]  | pulse_low_in[1];
        status1_d[0]  = status1_d[0]  | pulse_low_in[0];
        // live bits are never stored; the view adds them back
        status1_d[13] = 1'b0;
        status1_d[11] = 1'b0;
        status1_d[9]  = 1'b0;
    end

    // second status: per-channel line flags, read clears except confirm-cleared ones
    always @* begin
        status2_d = status2_q;
        if (rd_s2) begin
            status2_d = status2_q & 16'h0606;
        end
        // confirm writes clear the short-ground and overheat pair
        if (wr_ctrl && !reg_wdata_in[`CC_LINE_EN2]) begin
            status2_d[10] = 1'b0;
            status2_d[9]  = 1'b0;
        end
        if (wr_ctrl && !reg_wdata_in[`CC_LINE_EN1]) begin
            status2_d[2] = 1'b0;
            status2_d[1] = 1'b0;
        end
        // fresh faults are ORed in after every clear
        status2_d = status2_d | line_fault_in;
        // undervolt is live outside the coupling test, latched inside it
        if (!coupling_test_running_in) begin
            status2_d[8] = line_fault_in[8];
            status2_d[0] = line_fault_in[0];
        end
    end

    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            status1_q <= 16'h0000;
            status2_q <= 16'h0000;
        end else begin
            status1_q <= status1_d;
            status2_q <= status2_d;
        end
    end

    // third status sticky bits; reset flag left set by any reset
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            queue_lock_q  <= 1'b0;
            pin_level_q   <= 2'h0;
            clock_fault_q <= 1'b0;
            reset_seen_q  <= 1'b1;
        end else begin
            // full-read takes priority, so a lock is never missed
            if (queue_full_read_in) begin
                queue_lock_q <= 1'b1;
            end else if (queue_empty_in) begin
                queue_lock_q <= 1'b0;
            end
            // read clears first, then fresh sets are ORed in
            pin_level_q   <= (rd_s3 ? 2'h0 : pin_level_q) | pin_stuck_high_in;
            clock_fault_q <= (rd_s3 ? 1'b0 : clock_fault_q) | clock_fault_reset_in;
            reset_seen_q  <= rd_s3 ? 1'b0 : reset_seen_q;
        end
    end

    // register views
    // reads see stored flags merged with the live bits
    assign status1_view = status1_q | live1;
    assign status2_view = status2_q;
    assign status3_view = {selftest_write_enable_in, init_data_ready_in, regulator_on_in, queue_lock_q,
                           2'b00, pin_level_q[1], buffer_pending_in[1], line_on_in[1], 1'b0,
                           pin_level_q[0], buffer_pending_in[0], line_on_in[0], 1'b0,
                           clock_fault_q, reset_seen_q};

    // summary bit hides battery and undervolt during the coupling test
    assign sum_mask = coupling_test_running_in ? 16'hee_ee : 16'hffff;
    // masking only hides bits from the summary; the register still shows them
    assign summary_status_bit_out = |(status2_view & sum_mask);
    // global word: summary, any first status, any third status, reset flag
    assign global_status_out = {summary_status_bit_out, |status1_view, |status3_view[15:1],
                                reset_seen_q, 12'h000};

    // registered read data; no-operation returns global status only
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            // data holds between reads, so a slow host may sample late
            case (reg_addr_in)
                `ADDR_CHANNEL_CONTROL: reg_rdata_out <= ctrl_q;
                `ADDR_NO_OPERATION:    reg_rdata_out <= global_status_out;
                `ADDR_STATUS_FIRST:    reg_rdata_out <= status1_view;
                `ADDR_STATUS_SECOND:   reg_rdata_out <= status2_view;
                `ADDR_STATUS_THIRD:    reg_rdata_out <= status3_view;
                // reserved and unmapped indices read zero
                default:               reg_rdata_out <= 16'h0000;
            endcase
        end
    end

endmodule // sensor_channel_ctrl_status_regs

// File: dv/sensor_channel_regs_asserts.sv
// port checker for the channel register bank
`timescale 1ns/1ps
`include "sensor_channel_regs_defines.vh"
module sensor_channel_regs_asserts (
    // clock, reset and register port
    input wire        clock_in,
    input wire        sys_rst_in,
    input wire [5:0]  reg_addr_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [15:0] reg_wdata_in,
    input wire [15:0] reg_rdata_out,
    // outputs and mode inputs
    input wire [15:0] global_status_out,
    input wire        regulator_enable_out,
    input wire [1:0]  line_enable_out,
    input wire [1:0]  pulse_permit_out,
    input wire [1:0]  short_pulse_req_out,
    input wire [1:0]  long_pulse_req_out,
    input wire [1:0]  sync_mode_in,
    input wire [1:0]  buffer_in_use_in
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // write decode; plain mode keeps buffer and permit effects out of the pulse check
    wire ctrl_wr = reg_wr_in && reg_addr_in == `ADDR_CHANNEL_CONTROL;
    wire plain1  = !sync_mode_in[0] && !buffer_in_use_in[0];
    reset_value_a: assert property (disable iff (1'b0) sys_rst_in |=> regulator_enable_out && !line_enable_out)
        else $error("control outputs off reset value");
    reg_enable_a: assert property (ctrl_wr |=> regulator_enable_out == $past(reg_wdata_in[10]))
        else $error("regulator enable not written");
    line_enable_a: assert property (ctrl_wr |=> line_enable_out == {$past(reg_wdata_in[5]), $past(reg_wdata_in[0])})
        else $error("line enables not written");
    short_ch1_a: assert property (ctrl_wr && plain1 && line_enable_out[0] && reg_wdata_in[0] && reg_wdata_in[4:3] == 2'h1
        |=> short_pulse_req_out[0] && !long_pulse_req_out[0]) else $error("short pulse missing");
    idle_code_a: assert property (ctrl_wr && !(^reg_wdata_in[4:3]) && !(^reg_wdata_in[9:8])
        |=> short_pulse_req_out == 2'h0 && long_pulse_req_out == 2'h0) else $error("pulse on idle code");
    pulse_once_a: assert property (short_pulse_req_out[0] || long_pulse_req_out[0] |-> $past(ctrl_wr && line_enable_out[0]))
        else $error("pulse without enabled write");
    permit_mode_a: assert property ((pulse_permit_out | sync_mode_in) == 2'h3)
        else $error("permit not forced outside sync mode");
    reserved_zero_a: assert property (global_status_out[11:0] == 12'h000)
        else $error("global status reserved bits set");
    unmapped_read_a: assert property (reg_rd_in && (reg_addr_in < 6'h02 || reg_addr_in > 6'h06) |=> !reg_rdata_out)
        else $error("unmapped read not zero");
    reset_flag_a: assert property ($fell(sys_rst_in) |-> global_status_out[12])
        else $error("reset flag missing after reset");
    // main scenarios
    cover property (short_pulse_req_out != 2'h0);
    cover property (long_pulse_req_out != 2'h0);
    cover property (reg_rd_in && reg_addr_in == `ADDR_STATUS_FIRST);
endmodule // sensor_channel_regs_asserts

bind sensor_channel_ctrl_status_regs sensor_channel_regs_asserts u_asserts (.*);

// File: dv/host_model.sv
// host-side model driving the register port
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire        clock_in,
    // register port toward the block
    output reg  [5:0]  reg_addr_out  = 6'h00,
    output reg         reg_wr_out    = 1'b0,
    output reg         reg_rd_out    = 1'b0,
    output reg  [15:0] reg_wdata_out = 16'h0000,
    input  wire [15:0] reg_rdata_in
);
    // whole word per write; idle lines show inverted values so stale data never looks valid
    task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
        @(negedge clock_in) {reg_addr_out, reg_wdata_out, reg_wr_out} = {a, d, 1'b1};
        @(negedge clock_in) {reg_addr_out, reg_wdata_out, reg_wr_out} = {~a, ~d, 1'b0};
    endtask
    // read word is registered at the read edge
    task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
        @(negedge clock_in) {reg_addr_out, reg_rd_out} = {a, 1'b1};
        @(negedge clock_in) {reg_addr_out, reg_rd_out} = {~a, 1'b0};
        d = reg_rdata_in;
    endtask
endmodule // host_model

// File: dv/tb_top.sv
// self-checking bench for the channel register bank
`timescale 1ns/1ps
`include "sensor_channel_regs_defines.vh"
module tb_top;
    // stimulus, register port and observed outputs
    logic        clock_in, sys_rst_in, clock_fault_reset_in, queue_full_read_in, queue_empty_in, reg_wr_in, reg_rd_in;
    logic        selftest_write_enable_in, init_data_ready_in, regulator_on_in, summary_status_bit_out;
    logic        regulator_enable_out;
    logic [1:0]  sync_mode_in, buffer_in_use_in, buffer_pending_in, line_on_in, pin_stuck_high_in, trigger_pin_in;
    logic [1:0]  line_enable_out, pulse_permit_out, short_pulse_req_out, long_pulse_req_out;
    logic [5:0]  reg_addr_in;
    logic [15:0] line_fault_in, mon, reg_wdata_in, reg_rdata_out, global_status_out;
    int          bad_count = 0, compares = 0;
    localparam logic [5:0] a_cc = `ADDR_CHANNEL_CONTROL, a_np = `ADDR_NO_OPERATION;
    localparam logic [5:0] a_s1 = `ADDR_STATUS_FIRST, a_s2 = `ADDR_STATUS_SECOND, a_s3 = `ADDR_STATUS_THIRD;
    // monitor inputs packed in status-first bit order
    sensor_channel_ctrl_status_regs u_dut (.*,
        .coupling_test_done_in(mon[15]), .coupling_test_aborted_in(mon[14]), .coupling_test_running_in(mon[13]),
        .port_fault_in(mon[12]), .trim_crc_error_in(mon[11]), .regulator_undervolt_in(mon[10]),
        .regulator_overvolt_in(mon[9]), .regulator_lockout_in(mon[8]), .pulse_active_in({mon[7], mon[3]}),
        .buffer_write_in({mon[6], mon[2]}), .pulse_slow_in({mon[5], mon[1]}), .pulse_low_in({mon[4], mon[0]}));
    host_model u_host (.clock_in(clock_in), .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
        .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
    // 100 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // compare, count and report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_host.read_reg(a, d);
        chk($sformatf("register %h", a), e, d);
    endtask
    function automatic logic [15:0] reqs();
        return {12'h0, short_pulse_req_out, long_pulse_req_out};
    endfunction
    function automatic logic [15:0] ctl();
        return {11'h0, regulator_enable_out, line_enable_out, pulse_permit_out};
    endfunction
    task automatic t_reset();
        chk("control outputs", 16'h0013, ctl());
        rdc(a_np, 16'h1000);
        u_host.write_reg(a_np, 16'hffff);
        rdc(a_cc, 16'h0442);
        rdc(a_s3, 16'h0001);
        rdc(a_s3, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        u_host.write_reg(a_cc, 16'hffff);
        rdc(a_cc, 16'h077b);
        rdc(6'h3f, 16'h0000);
        chk("control outputs", 16'h001f, ctl());
        sync_mode_in = 2'h3;
        u_host.write_reg(a_cc, 16'h0040);
        chk("control outputs", 16'h0002, ctl());
        sync_mode_in = 2'h0;
        u_host.write_reg(a_cc, 16'h0021);
        for (int c = 0; c < 4; c++) begin
            u_host.write_reg(a_cc, 16'h0021 | 16'(c) << 3 | 16'(c) << 8);
            chk("pulse requests", c == 1 ? 16'h000c : c == 2 ? 16'h0003 : 16'h0000, reqs());
            @(negedge clock_in);
            chk("pulse requests", 16'h0000, reqs());
        end
        buffer_in_use_in = 2'h3;
        u_host.write_reg(a_cc, 16'h0231);
        chk("pulse requests", 16'h000c, reqs());
        buffer_in_use_in = 2'h0;
        u_host.write_reg(a_cc, 16'h0108);
        chk("pulse requests", 16'h0000, reqs());
        $display("test control done");
    endtask
    task automatic t_first();
        int lat[10] = '{15, 14, 12, 10, 6, 5, 4, 2, 1, 0};
        int liv[3] = '{13, 11, 9};
        buffer_pending_in = 2'h3;
        foreach (lat[i]) begin
            @(negedge clock_in) mon[lat[i]] = 1'b1;
            @(negedge clock_in) mon[lat[i]] = 1'b0;
            rdc(a_s1, 16'h1 << lat[i]);
            rdc(a_s1, 16'h0000);
        end
        buffer_pending_in = 2'h0;
        foreach (liv[i]) begin
            mon[liv[i]] = 1'b1;
            rdc(a_s1, 16'h1 << liv[i]);
            rdc(a_s1, 16'h1 << liv[i]);
            mon[liv[i]] = 1'b0;
            rdc(a_s1, 16'h0000);
        end
        @(negedge clock_in) mon[8] = 1'b1;
        @(negedge clock_in) mon[8] = 1'b0;
        rdc(a_s1, 16'h0100);
        rdc(a_s1, 16'h0100);
        u_host.write_reg(a_cc, 16'h0000);
        rdc(a_s1, 16'h0000);
        $display("test status first done");
    endtask
    task automatic t_second();
        @(negedge clock_in) line_fault_in = 16'hfefe;
        @(negedge clock_in) line_fault_in = 16'h0000;
        chk("summary bit", 16'h0001, {15'h0, summary_status_bit_out});
        rdc(a_s2, 16'hfefe);
        rdc(a_s2, 16'h0606);
        u_host.write_reg(a_cc, 16'h0000);
        rdc(a_s2, 16'h0000);
        mon[13] = 1'b1;
        @(negedge clock_in) line_fault_in = 16'h1111;
        @(negedge clock_in) line_fault_in = 16'h0000;
        chk("summary bit", 16'h0000, {15'h0, summary_status_bit_out});
        rdc(a_s2, 16'h1111);
        mon[13] = 1'b0;
        $display("test status second done");
    endtask
    task automatic t_third();
        {selftest_write_enable_in, init_data_ready_in, regulator_on_in, line_on_in, buffer_pending_in} = 7'h7f;
        rdc(a_s3, 16'he198);
        rdc(a_s3, 16'he198);
        {selftest_write_enable_in, init_data_ready_in, regulator_on_in, line_on_in, buffer_pending_in} = 7'h00;
        queue_empty_in = 1'b0;
        @(negedge clock_in) {pin_stuck_high_in, clock_fault_reset_in, queue_full_read_in} = 4'hf;
        @(negedge clock_in) {pin_stuck_high_in, clock_fault_reset_in, queue_full_read_in} = 4'h0;
        rdc(a_s3, 16'h1222);
        rdc(a_s3, 16'h1000);
        queue_empty_in = 1'b1;
        rdc(a_s3, 16'h0000);
        $display("test status third done");
    endtask
    task automatic t_pin();
        {trigger_pin_in, mon[3]} = 3'h3;
        repeat (9990) @(negedge clock_in);
        rdc(a_s1, 16'h0000);
        repeat (30) @(negedge clock_in);
        {trigger_pin_in, mon[3]} = 3'h0;
        rdc(a_s1, 16'h0008);
        $display("test pin timeout done");
    endtask
    // verdict and end of run
    task automatic complete_run();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog: tests need about 10200 cycles
    initial begin
        #300000;
        bad_count++;
        complete_run();
    end
    // reset for ten cycles, then the tests
    initial begin
        {sys_rst_in, queue_empty_in, clock_fault_reset_in, queue_full_read_in} = 4'hc;
        {selftest_write_enable_in, init_data_ready_in, regulator_on_in} = 3'h0;
        {sync_mode_in, buffer_in_use_in, buffer_pending_in, line_on_in, pin_stuck_high_in, trigger_pin_in} = 12'h000;
        {line_fault_in, mon} = 32'h0;
        repeat (10) @(negedge clock_in);
        sys_rst_in = 1'b0;
        t_reset();
        t_ctrl();
        t_first();
        t_second();
        t_third();
        t_pin();
        complete_run();
    end
endmodule // tb_top
